// *** logic/sar_flag.sv ***
// One monitor flag: two-flop synchroniser, live copy and sticky copy.
// Assumes the raw input comes from analog logic with no relation to core_clk.
`timescale 1ns/10ps
module sar_flag
   import sar_pkg::*;
#(
   parameter bit LATCH_HIGH = 1'b1
)
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic rawAsync,
   input wire logic readClear,
   output logic live,
   output logic latched
);

   logic syncFirst;
   logic prevLive;
   logic edgeSeen;

   // Two flops before anything looks at the pin.
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         syncFirst <= 1'b0;
         live <= 1'b0;
         prevLive <= 1'b0;
      end
      else
      begin
         syncFirst <= rawAsync;
         live <= syncFirst;
         prevLive <= live;
      end
   end

   assign edgeSeen = LATCH_HIGH ? (live & ~prevLive) : (~live & prevLive);

   // The edge wins over a read in the same cycle so no event is lost.
   // A read reloads the low-type copy from the live level, so it stays low if still low.
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         latched <= 1'b0;
      else if (edgeSeen)
         latched <= LATCH_HIGH; // R3 R4
      else if (readClear)
         latched <= LATCH_HIGH ? 1'b0 : live; // R3 R4
   end

   a_latch_catch: assert property (@(posedge core_clk) disable iff (!reset_n) // R3 R4
      edgeSeen |=> (latched == LATCH_HIGH))
      else $error("Sticky flag missed its edge.");

   a_latch_holds: assert property (@(posedge core_clk) disable iff (!reset_n) // R3
      (!edgeSeen && !readClear) |=> $stable(latched))
      else $error("Sticky flag changed without edge or read.");

endmodule : sar_flag

// *** logic/sar_pkg.sv ***
// Constants and carrier types for the status and adjustment register bank.
// Assumes a two-wire serial engine elsewhere that turns host frames into
// one-cycle byte read and write strobes on core_clk, addressed by register number.
//
// Contract
// R1: 10-bit result split high byte, low two bits.
// R2: Receive status bit 7 shows live unlock.
// R3: Bit 6 latches low lock, restored on read.
// R4: Receive bit 5 live loss, bit 4 latched high.
// R5: Transmit status bit 7 shows live unlock.
// R6: Transmit status bit 5 shows live fault.
// R7: Transmit status bit 4 shows driver disabled.
// R8: Adjust bits 7:5 select loop resistor code.
// R9: Adjust register resets to 40h.
// R10: Registers 20 to 39 reserved.
// R11: Registers 44 to 50 reserved.
// R12: Receive status resets zero, low nibble zero.
// R13: Writes to read-only registers are ignored.
package sar_pkg;

   // Register numbers, also the index carried on the register port.
   localparam logic [5:0] SAR_RSVD_LOW_FIRST = 6'h14;
   localparam logic [5:0] SAR_RSVD_LOW_LAST = 6'h27;
   localparam logic [5:0] SAR_RESULT_HIGH = 6'h28;
   localparam logic [5:0] SAR_RESULT_LOW = 6'h29;
   localparam logic [5:0] SAR_RX_STATUS = 6'h2A;
   localparam logic [5:0] SAR_TX_STATUS = 6'h2B;
   localparam logic [5:0] SAR_RSVD_HIGH_FIRST = 6'h2C;
   localparam logic [5:0] SAR_RSVD_HIGH_LAST = 6'h32;
   localparam logic [5:0] SAR_LOOP_ADJUST = 6'h33;

   // Field positions.
   localparam int SAR_UNLOCK_BIT = 7;
   localparam int SAR_LOCK_LATCH_BIT = 6;
   localparam int SAR_LOSS_BIT = 5;
   localparam int SAR_LOSS_LATCH_BIT = 4;
   localparam int SAR_FAULT_BIT = 5;
   localparam int SAR_DRV_OFF_BIT = 4;
   localparam int SAR_RES_SEL_MSB = 7;
   localparam int SAR_RES_SEL_LSB = 5;

   // Values after reset.
   localparam logic [7:0] SAR_ADJUST_RESET = 8'h40;
   localparam logic [9:0] SAR_RESULT_RESET = 10'h000;
   localparam logic [7:0] SAR_BYTE_ZERO = 8'h00;

   // One register port request; rd and wr are one-cycle strobes.
   typedef struct packed {
      logic rd;
      logic wr;
      logic [5:0] addr;
      logic [7:0] wdata;
   } sar_reg_req_t;

   // Synchronised live flags from the analog monitors.
   typedef struct packed {
      logic rxUnlocked;
      logic rxLoss;
      logic txUnlocked;
      logic txFault;
      logic txDriverOff;
   } sar_live_t;

endpackage : sar_pkg

// *** logic/sar_regs.sv ***
// Status and adjustment register bank: converter result, receive and
// transmit status with sticky flags, and the loop-filter resistor select.
// Assumes a serial engine on core_clk issues one-cycle rd/wr strobes by
// register number and samples readData on the cycle after rd.
`timescale 1ns/10ps
module sar_regs
   import sar_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire sar_reg_req_t regReq,
   output logic [7:0] readData,
   output logic regHit,
   input wire logic [9:0] convResult,
   input wire logic convValid,
   input wire logic rxRecoveryUnlockedRaw,
   input wire logic rxSignalLossRaw,
   input wire logic txRecoveryUnlockedRaw,
   input wire logic txFaultFlagRaw,
   input wire logic txDriverOffFlagRaw,
   output logic [2:0] loopResSel
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations and decode.

   sar_live_t liveFlags;
   logic [9:0] convStore;
   logic [7:0] loopAdjust;
   logic rxLockLatched;
   logic rxLossLatched;
   logic txLockLatched;
   logic rxReadClear;
   logic txReadClear;
   logic [7:0] next_readData;

   // True for register numbers that sit in either reserved range.
   function automatic logic isReserved(input logic [5:0] addr);
      isReserved = ((addr >= SAR_RSVD_LOW_FIRST) && (addr <= SAR_RSVD_LOW_LAST)) ||
                   ((addr >= SAR_RSVD_HIGH_FIRST) && (addr <= SAR_RSVD_HIGH_LAST));
   endfunction : isReserved

   // The bank answers from the first reserved number up to the adjust register.
   assign regHit = (regReq.addr >= SAR_RSVD_LOW_FIRST) && (regReq.addr <= SAR_LOOP_ADJUST);

   // Sticky bits clear only on a read that this bank actually answers.
   assign rxReadClear = regReq.rd && (regReq.addr == SAR_RX_STATUS);
   assign txReadClear = regReq.rd && (regReq.addr == SAR_TX_STATUS);

   ////////////////////////////////////////////////////////////////////////////
   // Monitor flags, each synchronised before use.

   sar_flag #(.LATCH_HIGH(1'b0)) rxLockFlag (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .rawAsync(rxRecoveryUnlockedRaw),
      .readClear(rxReadClear),
      .live(liveFlags.rxUnlocked),
      .latched(rxLockLatched)
   );

   sar_flag #(.LATCH_HIGH(1'b1)) rxLossFlag (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .rawAsync(rxSignalLossRaw),
      .readClear(rxReadClear),
      .live(liveFlags.rxLoss),
      .latched(rxLossLatched)
   );

   sar_flag #(.LATCH_HIGH(1'b0)) txLockFlag (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .rawAsync(txRecoveryUnlockedRaw),
      .readClear(txReadClear),
      .live(liveFlags.txUnlocked),
      .latched(txLockLatched)
   );

   // Fault and driver-off have no sticky copy; the latched outputs are unused.
   sar_flag #(.LATCH_HIGH(1'b1)) txFaultSync (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .rawAsync(txFaultFlagRaw),
      .readClear(1'b0),
      .live(liveFlags.txFault),
      .latched()
   );

   sar_flag #(.LATCH_HIGH(1'b1)) txDriverOffSync (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .rawAsync(txDriverOffFlagRaw),
      .readClear(1'b0),
      .live(liveFlags.txDriverOff),
      .latched()
   );

   ////////////////////////////////////////////////////////////////////////////
   // Converter result capture.

   // Both halves come from one stored word, so a host reading high then low
   // may see halves of two conversions; the store only moves on convValid.
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         convStore <= SAR_RESULT_RESET;
      else if (convValid)
         convStore <= convResult; // R1
   end

   ////////////////////////////////////////////////////////////////////////////
   // Loop-filter adjust register, the only writable byte here.

   // Writes to any other number, read-only or reserved, are dropped.
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         loopAdjust <= SAR_ADJUST_RESET; // R9
      else if (regReq.wr && (regReq.addr == SAR_LOOP_ADJUST))
         loopAdjust <= regReq.wdata; // R13
   end

   // Code 0 is the smallest resistor, each step adds the same amount.
   assign loopResSel = loopAdjust[SAR_RES_SEL_MSB:SAR_RES_SEL_LSB]; // R8

   ////////////////////////////////////////////////////////////////////////////
   // Read multiplexer.

   // Reserved numbers and anything outside the bank read as zero.
   always_comb
   begin
      next_readData = SAR_BYTE_ZERO; // R10 R11
      if (!isReserved(regReq.addr))
      begin
         unique case (regReq.addr)
            SAR_RESULT_HIGH: next_readData = convStore[9:2]; // R1
            SAR_RESULT_LOW: next_readData = {6'h00, convStore[1:0]}; // R1
            SAR_RX_STATUS:
            begin
               next_readData[SAR_UNLOCK_BIT] = liveFlags.rxUnlocked; // R2
               next_readData[SAR_LOCK_LATCH_BIT] = rxLockLatched; // R3
               next_readData[SAR_LOSS_BIT] = liveFlags.rxLoss; // R4
               next_readData[SAR_LOSS_LATCH_BIT] = rxLossLatched; // R4 R12
            end
            SAR_TX_STATUS:
            begin
               next_readData[SAR_UNLOCK_BIT] = liveFlags.txUnlocked; // R5
               next_readData[SAR_LOCK_LATCH_BIT] = txLockLatched; // R3
               next_readData[SAR_FAULT_BIT] = liveFlags.txFault; // R6
               next_readData[SAR_DRV_OFF_BIT] = liveFlags.txDriverOff; // R7
            end
            SAR_LOOP_ADJUST: next_readData = loopAdjust;
            default: next_readData = SAR_BYTE_ZERO;
         endcase
      end
   end

   // Read data is registered and holds until the next read strobe.
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         readData <= SAR_BYTE_ZERO;
      else if (regReq.rd)
         readData <= next_readData;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   a_result_high: assert property (@(posedge core_clk) disable iff (!reset_n) // R1
      (regReq.rd && regReq.addr == SAR_RESULT_HIGH) |=> readData == $past(convStore[9:2]))
      else $error("Result high byte read wrong.");

   a_result_low: assert property (@(posedge core_clk) disable iff (!reset_n) // R1
      (regReq.rd && regReq.addr == SAR_RESULT_LOW) |=>
      (readData[7:2] == 6'h00) && (readData[1:0] == $past(convStore[1:0])))
      else $error("Result low byte read wrong.");

   a_rx_live_bits: assert property (@(posedge core_clk) disable iff (!reset_n) // R2 R4
      (regReq.rd && regReq.addr == SAR_RX_STATUS) |=>
      (readData[7] == $past(liveFlags.rxUnlocked)) && (readData[5] == $past(liveFlags.rxLoss)))
      else $error("Receive live flags read wrong.");

   a_rx_low_nibble: assert property (@(posedge core_clk) disable iff (!reset_n) // R12
      (regReq.rd && regReq.addr == SAR_RX_STATUS) |=> readData[3:0] == 4'h0)
      else $error("Receive status low nibble not zero.");

   a_tx_live_bits: assert property (@(posedge core_clk) disable iff (!reset_n) // R5 R6 R7
      (regReq.rd && regReq.addr == SAR_TX_STATUS) |=>
      (readData[7:4] == {$past(liveFlags.txUnlocked), $past(txLockLatched),
                         $past(liveFlags.txFault), $past(liveFlags.txDriverOff)}))
      else $error("Transmit status read wrong.");

   a_reserved_zero: assert property (@(posedge core_clk) disable iff (!reset_n) // R10 R11
      (regReq.rd && isReserved(regReq.addr)) |=> readData == 8'h00)
      else $error("Reserved register read nonzero.");

   a_adjust_reset: assert property (@(posedge core_clk) // R9
      (!reset_n) ##1 (reset_n && !$past(regReq.wr)) |-> loopAdjust == 8'h40)
      else $error("Adjust register reset value wrong.");

   a_res_select: assert property (@(posedge core_clk) disable iff (!reset_n) // R8
      (regReq.wr && regReq.addr == SAR_LOOP_ADJUST) |=> loopResSel == $past(regReq.wdata[7:5]))
      else $error("Resistor select did not follow write.");

   a_ro_write: assert property (@(posedge core_clk) disable iff (!reset_n) // R13
      (regReq.wr && regReq.addr != SAR_LOOP_ADJUST) |=> $stable(loopAdjust))
      else $error("Write to read-only number changed state.");

   // A read with no new rise in the same cycle must leave the sticky loss bit clear.
   a_sticky_clear: assert property (@(posedge core_clk) disable iff (!reset_n) // R4
      (rxReadClear && !$rose(liveFlags.rxLoss)) |=> !rxLossLatched)
      else $error("Loss sticky flag not cleared by read.");

   // A read with no new fall reloads the sticky lock bit from the live level.
   a_lock_reload: assert property (@(posedge core_clk) disable iff (!reset_n) // R3
      (rxReadClear && !$fell(liveFlags.rxUnlocked)) |=>
      (rxLockLatched == $past(liveFlags.rxUnlocked)))
      else $error("Lock sticky flag not restored by read.");

endmodule : sar_regs

// *** tb/sar_host_model.sv ***
// Host side of the register port: issues one read or write at a time.
// Assumes the bank takes a strobe at a rising edge and answers one cycle later.
`timescale 1ns/10ps
module sar_host_model
   import sar_pkg::*;
(
   input wire logic core_clk,
   input wire logic [7:0] readData,
   output sar_reg_req_t regReq
);

   ////////////////////////////////////////////////////////////////////////////
   // The port is idle from time zero so no strobe is seen during reset.
   initial regReq = '{rd: 1'b0, wr: 1'b0, addr: 6'h00, wdata: 8'h00};

   // One transfer: strobe for one edge, then release and take the answer.
   task automatic access(input logic isWr, input logic [5:0] a, input logic [7:0] d,
                         output logic [7:0] q);
      @(posedge core_clk);
      regReq <= '{rd: ~isWr, wr: isWr, addr: a, wdata: d};
      @(posedge core_clk);
      // Released lines show the inverse, so a stale sample cannot pass for a match.
      regReq <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
      #1;
      q = readData;
   endtask : access

endmodule : sar_host_model

// *** tb/tb.sv ***
// Self-checking bench for the status and adjustment register bank.
// Assumes the host model drives the port and the bench drives the monitor flags.
`timescale 1ns/10ps
`define CHK(a, e) begin samplesChecked++; if ((a) !== (e)) begin numErrors++; \
   $display("wrong value at %0t ns: got %h expected %h", $time, a, e); end end
module tb
   import sar_pkg::*;
;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [9:0] convResult = 10'h000;
   logic convValid = 1'b0;
   logic [4:0] rawFlags = 5'h00;
   sar_reg_req_t regReq;
   logic [7:0] readData;
   logic regHit;
   logic [2:0] loopResSel;
   int numErrors = 0;
   int samplesChecked = 0;

   ////////////////////////////////////////////////////////////////////////////
   // Clock at 20 MHz.
   always #25 core_clk = ~core_clk;

   sar_regs sar_regs_i (.core_clk(core_clk), .reset_n(reset_n), .regReq(regReq),
      .readData(readData), .regHit(regHit), .convResult(convResult), .convValid(convValid),
      .rxRecoveryUnlockedRaw(rawFlags[4]), .rxSignalLossRaw(rawFlags[3]),
      .txRecoveryUnlockedRaw(rawFlags[2]), .txFaultFlagRaw(rawFlags[1]),
      .txDriverOffFlagRaw(rawFlags[0]), .loopResSel(loopResSel));

   sar_host_model sar_host_model_i (.core_clk(core_clk), .readData(readData),
      .regReq(regReq));

   ////////////////////////////////////////////////////////////////////////////
   // Verdict and end of run, shared by the main sequence and the watchdog.
   task automatic testDone();
      if (numErrors == 0 && samplesChecked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : testDone

   // Read one register and compare it with the expected byte.
   task automatic chkRd(input logic [5:0] a, input logic [7:0] e);
      logic [7:0] q;
      sar_host_model_i.access(1'b0, a, 8'h00, q);
      `CHK(q, e)
   endtask : chkRd

   // Write one register; the read byte is of no interest.
   task automatic wrReg(input logic [5:0] a, input logic [7:0] d);
      logic [7:0] q;
      sar_host_model_i.access(1'b1, a, d, q);
   endtask : wrReg

   // Flags cross a synchroniser and an edge detector, so five edges let them settle.
   task automatic setFlags(input logic [4:0] f);
      @(posedge core_clk);
      rawFlags <= f;
      repeat (5) @(posedge core_clk);
   endtask : setFlags

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence: reset values, resistor codes, reserved places, result, flags.
   initial
   begin
      repeat (4) @(posedge core_clk);
      reset_n <= 1'b1;
      chkRd(SAR_LOOP_ADJUST, SAR_ADJUST_RESET);
      `CHK(loopResSel, 3'h2)
      chkRd(SAR_RX_STATUS, 8'h00);
      chkRd(SAR_TX_STATUS, 8'h00);
      chkRd(SAR_RESULT_HIGH, 8'h00);
      chkRd(SAR_RESULT_LOW, 8'h00);
      for (int c = 0; c < 8; c++)
      begin
         wrReg(SAR_LOOP_ADJUST, {c[2:0], 5'h15});
         `CHK(loopResSel, c[2:0])
         chkRd(SAR_LOOP_ADJUST, {c[2:0], 5'h15});
      end
      wrReg(SAR_LOOP_ADJUST, SAR_ADJUST_RESET);
      // Writes into reserved places must leave them reading zero.
      for (int a = 20; a <= 50; a++)
      begin
         if (a < 40 || a > 43)
         begin
            wrReg(a[5:0], 8'hFF);
            chkRd(a[5:0], 8'h00);
         end
      end
      chkRd(6'h3F, 8'h00);
      // The released port now shows number 0, which lies outside the bank.
      `CHK(regHit, 1'b0)
      chkRd(SAR_RSVD_LOW_FIRST, 8'h00);
      // Now it shows the inverse of 20, which is 43 and inside the bank.
      `CHK(regHit, 1'b1)
      chkRd(SAR_LOOP_ADJUST, SAR_ADJUST_RESET);
      @(posedge core_clk);
      convResult <= 10'h2B7;
      convValid <= 1'b1;
      @(posedge core_clk);
      convValid <= 1'b0;
      wrReg(SAR_RESULT_HIGH, 8'h00);
      wrReg(SAR_RESULT_LOW, 8'hFF);
      chkRd(SAR_RESULT_HIGH, 8'hAD);
      chkRd(SAR_RESULT_LOW, 8'h03);
      // Flag order is rx unlock, rx loss, tx unlock, tx fault, driver off.
      setFlags(5'b10000);
      chkRd(SAR_RX_STATUS, 8'h80);
      chkRd(SAR_RX_STATUS, 8'hC0);
      setFlags(5'b00000);
      setFlags(5'b10000);
      chkRd(SAR_RX_STATUS, 8'h80);
      chkRd(SAR_RX_STATUS, 8'hC0);
      setFlags(5'b11000);
      chkRd(SAR_RX_STATUS, 8'hF0);
      // That read cleared the sticky loss bit, and a falling flag must not set it.
      setFlags(5'b10000);
      chkRd(SAR_RX_STATUS, 8'hC0);
      // A rise and a fall with no read between leave the sticky bit up.
      setFlags(5'b11000);
      setFlags(5'b10000);
      chkRd(SAR_RX_STATUS, 8'hD0);
      chkRd(SAR_RX_STATUS, 8'hC0);
      wrReg(SAR_RX_STATUS, 8'h0F);
      chkRd(SAR_RX_STATUS, 8'hC0);
      setFlags(5'b10111);
      chkRd(SAR_TX_STATUS, 8'hB0);
      chkRd(SAR_TX_STATUS, 8'hF0);
      setFlags(5'b10100);
      chkRd(SAR_TX_STATUS, 8'hC0);
      setFlags(5'b10000);
      chkRd(SAR_TX_STATUS, 8'h00);
      chkRd(SAR_TX_STATUS, 8'h00);
      // A reset in mid-run must bring the resistor code back to its default.
      wrReg(SAR_LOOP_ADJUST, 8'hE0);
      `CHK(loopResSel, 3'h7)
      @(posedge core_clk);
      reset_n <= 1'b0;
      @(posedge core_clk);
      reset_n <= 1'b1;
      `CHK(loopResSel, 3'h2)
      chkRd(SAR_LOOP_ADJUST, SAR_ADJUST_RESET);
      testDone();
   end

   // Watchdog: the sequence needs well under a thousand cycles.
   initial
   begin
      repeat (4000) @(posedge core_clk);
      numErrors++;
      testDone();
   end

endmodule : tb
